// [core/csdcc_defines.svh]
/*
 * offsets, field positions, reset values and phase numbers of the
 * cycle-steal data channel. assumes a 32-bit AHB-Lite word bus.
 */
`ifndef CSDCC_DEFINES_SVH
`define CSDCC_DEFINES_SVH
`define CSDCC_OFS_IO_CONTROL_COMMAND_WORD_ADDR 8'h00
`define CSDCC_OFS_IO_CONTROL_COMMAND_WORD_CMD  8'h04
`define CSDCC_OFS_CTRL      8'h08
`define CSDCC_OFS_TMASK     8'h0C
`define CSDCC_OFS_STATUS    8'h10
`define CSDCC_OFS_ACTIVE    8'h14
`define CSDCC_CMD_LVL_HI    3
`define CSDCC_CMD_FUNC_BIT  4
`define CSDCC_CTRL_RUN_BIT  0
`define CSDCC_CTRL_STEP_BIT 1
`define CSDCC_ST_XCHK_BIT   16
`define CSDCC_ST_BUSY_BIT   17
`define CSDCC_SCAN_LO       0
`define CSDCC_SCAN_HI       1
`define CSDCC_WC_LO         2
`define CSDCC_WC_HI         15
`define CSDCC_NLEV          15
`define CSDCC_PH_LAST       3'h7
`define CSDCC_PH_CAB        3'h1
`define CSDCC_PH_DATA       3'h3
`define CSDCC_PH_INC        3'h4
`define CSDCC_PH_CHK        3'h5
`define CSDCC_CTL_SETCAR    3'h2
`define CSDCC_CTL_CHECK     3'h6
`define CSDCC_RST_CTRL      2'h0
`define CSDCC_RST_WORD      16'h0000
`endif

// [core/csdcc_pkg.sv]
/*
 * types of the cycle-steal data channel: mode, memory port bundle and
 * the whole register state. assumes csdcc_defines.svh is on the path.
 */
`include "csdcc_defines.svh"
package csdcc_pkg;
  typedef enum logic [0:0] {
    CSDCC_PROG  = 1'b0,
    CSDCC_STEAL = 1'b1
  } csdcc_mode_t;

  typedef struct packed {
    logic [15:0] addr;
    logic        rd;
    logic        wr;
    logic [15:0] wdata;
  } csdcc_mem_t;

  typedef struct packed {
    csdcc_mode_t      mode;
    logic [2:0]       ph;
    logic [3:0]       lvl;
    logic             second;
    logic [14:0]      prio;
    logic [14:0]      ack;
    logic [14:0][15:0] channel_address_reg;
    logic [15:0]      cab;
    logic [15:0]      bdata;
    logic [14:0]      func;
    logic [14:0]      first;
    logic             setcar;
    csdcc_mem_t       mem;
    logic [15:0]      out_bus;
    logic             out_stb;
    logic             t_hold;
    logic             m_block;
    logic [14:0]      chk;
    logic             chk_stb;
    logic             xio_chk;
    logic [1:0]       ctrl;
    logic [14:0]      tmask;
    logic [15:0]      io_control_command_word_addr;
    logic             a_wr;
    logic [7:0]       a_addr;
    logic [31:0]      hrdata;
  } csdcc_state_t;
endpackage : csdcc_pkg

// [core/csdcc_top.sv]
/*
 * cycle-steal data channel with data chaining, fifteen priority levels,
 * AHB-Lite register slave. assumes a synchronous memory that answers a
 * read strobe on the following clock and adapters that hold their
 * request and control lines steady across a stolen cycle.
 */
// Register access over AHB-Lite and the register addresses are this design's own decisions.
// Overview of operation
// RULE1 - scan bits sit in word bits 0-1
// RULE2 - 00 single scan, stop with interrupt
// RULE3 - bit0 set continuous; bit1 suppresses interrupt
// RULE4 - adapter loads scan bits and word count
// RULE5 - car addresses X0-X2, cab after, inc X4
// RULE6 - each word advances the address register
// RULE7 - transfers only on adapter request
// RULE8 - non-chaining adapter stops at zero count
// RULE9 - continuous scan holds request three cycles
// RULE10 - first chain cycle loads next table address
// RULE11 - second chain cycle checks self address
// RULE12 - adapter flags mismatch via control lines
// RULE13 - third chain cycle reloads count, advances
// RULE14 - zero count follows scan control setting
// RULE15 - level zero chain gap within three cycles
// RULE16 - priority set at T7, clock runs if enabled
// RULE17 - steal blocks processor one cycle, timer two; code holds M_BLOCK with T_HOLD, two cycles if tmask set
// RULE18 - first steal puts count word on out-bus
// RULE19 - write function reads, read function stores
// RULE20 - count zero raises end of table interrupt
// RULE21 - pending levels served before program resumes
// RULE22 - execute-io loads address register and checks
// RULE23 - levels 0 highest to 14 lowest
// RULE24 - granted level returned as acknowledge
// RULE25 - zero chained count ends the operation
`timescale 1ns/1ps
module csdcc_top (
  // clock and reset
  input  wire logic        CLK,
  input  wire logic        SYS_RST,
  // ahb-lite slave
  input  wire logic        HSEL,
  input  wire logic [31:0] HADDR,
  input  wire logic [1:0]  HTRANS,
  input  wire logic        HWRITE,
  input  wire logic [2:0]  HSIZE,
  input  wire logic [31:0] HWDATA,
  input  wire logic        HREADY,
  output logic      [31:0] HRDATA,
  output logic             HREADYOUT,
  output logic             HRESP,
  // adapters
  input  wire logic [14:0] CS_REQ,
  input  wire logic [2:0]  CS_CTRL,
  input  wire logic [15:0] IN_BUS,
  output logic      [14:0] CS_ACK,
  output logic      [15:0] OUT_BUS,
  output logic             OUT_STB,
  output logic             CHK_STB,
  // core storage and processor timing
  input  wire logic [15:0] MEM_RDATA,
  output logic      [15:0] MEM_ADDR,
  output logic             MEM_RD,
  output logic             MEM_WR,
  output logic      [15:0] MEM_WDATA,
  output logic             T_HOLD,
  output logic             M_BLOCK
);
  csdcc_pkg::csdcc_state_t r_reg;
  csdcc_pkg::csdcc_state_t r_next;

  logic        run;
  logic [3:0]  win;
  logic        any_req;
  logic        a_take;
  logic        rd_need;

  // fixed priority: lowest index wins
  always_comb begin
    win = 4'hF;
    for (int i = `CSDCC_NLEV - 1; i >= 0; i--) begin
      if (CS_REQ[i]) begin
        win = 4'(i); // RULE23
      end
    end
  end

  assign run     = |r_reg.ctrl;
  assign any_req = |CS_REQ;
  assign a_take  = HSEL && HTRANS[1] && HREADY;
  assign rd_need = r_reg.first[r_reg.lvl] || !r_reg.func[r_reg.lvl]
                   || CS_CTRL[1];

  always_comb begin
    r_next         = r_reg;
    r_next.out_stb = 1'b0;
    r_next.chk_stb = 1'b0;
    r_next.mem.rd  = 1'b0;
    r_next.mem.wr  = 1'b0;
    // ahb address phase, answered with zero wait states
    r_next.a_wr = a_take && HWRITE;
    r_next.a_addr = HADDR[7:0];
    if (a_take && !HWRITE) begin
      case (HADDR[7:0])
        `CSDCC_OFS_IO_CONTROL_COMMAND_WORD_ADDR: r_next.hrdata = {16'h0000, r_reg.io_control_command_word_addr};
        `CSDCC_OFS_CTRL:      r_next.hrdata = {30'h00000000, r_reg.ctrl};
        `CSDCC_OFS_TMASK:     r_next.hrdata = {17'h00000, r_reg.tmask};
        `CSDCC_OFS_STATUS:    r_next.hrdata = {14'h0000,
            r_reg.mode == csdcc_pkg::CSDCC_STEAL, r_reg.xio_chk,
            1'b0, r_reg.chk};
        `CSDCC_OFS_ACTIVE:    r_next.hrdata = {13'h0000, r_reg.lvl,
            r_reg.prio};
        default:              r_next.hrdata = 32'h00000000;
      endcase
    end else begin
      r_next.hrdata = 32'h00000000;
    end
    // processor timing and stolen cycles
    r_next.ph = r_reg.ph + 3'h1;
    case (r_reg.mode)
      csdcc_pkg::CSDCC_PROG: begin
        if (r_reg.ph == `CSDCC_PH_LAST) begin
          r_next.prio = CS_REQ; // RULE16
          if (run && any_req) begin // RULE7 RULE16
            r_next.mode     = csdcc_pkg::CSDCC_STEAL;
            r_next.lvl      = win;
            r_next.ack      = 15'h0001 << win; // RULE24
            r_next.t_hold   = 1'b1; // RULE17
            r_next.m_block  = 1'b1; // RULE17
            r_next.mem.addr = r_reg.channel_address_reg[win]; // RULE5
            r_next.second   = 1'b0;
          end
        end
      end
      csdcc_pkg::CSDCC_STEAL: begin
        case (r_reg.ph)
          `CSDCC_PH_CAB: begin
            r_next.cab      = r_reg.channel_address_reg[r_reg.lvl]; // RULE5
            r_next.mem.addr = r_reg.channel_address_reg[r_reg.lvl];
            r_next.mem.rd   = rd_need; // RULE18 RULE19
            r_next.setcar   = CS_CTRL == `CSDCC_CTL_SETCAR;
          end
          `CSDCC_PH_DATA: begin
            if (!r_reg.first[r_reg.lvl] && r_reg.func[r_reg.lvl]
                && !CS_CTRL[1]) begin
              r_next.bdata = IN_BUS; // RULE19
            end else begin
              r_next.bdata = MEM_RDATA;
            end
            if (r_reg.setcar) begin
              r_next.channel_address_reg[r_reg.lvl] = MEM_RDATA; // RULE10
            end
          end
          `CSDCC_PH_INC: begin
            if (!r_reg.setcar) begin
              r_next.channel_address_reg[r_reg.lvl] = r_reg.channel_address_reg[r_reg.lvl] + 16'h0001; // RULE5 RULE6 RULE13
            end
            if (r_reg.first[r_reg.lvl] || !r_reg.func[r_reg.lvl]
                || CS_CTRL[1]) begin
              r_next.out_bus = r_reg.bdata; // RULE1 RULE18 RULE19
              r_next.out_stb = 1'b1; // RULE20
            end else begin
              r_next.mem.wdata = r_reg.bdata; // RULE19
              r_next.mem.wr    = 1'b1; // RULE20
            end
          end
          `CSDCC_PH_CHK: begin
            if (CS_CTRL == `CSDCC_CTL_CHECK && r_reg.bdata != r_reg.cab) begin
              r_next.chk[r_reg.lvl] = 1'b1; // RULE11
              r_next.chk_stb        = 1'b1;
            end
            r_next.first[r_reg.lvl] = 1'b0;
          end
          `CSDCC_PH_LAST: begin
            r_next.prio = CS_REQ;
            if (r_reg.tmask[r_reg.lvl] && !r_reg.second) begin
              r_next.second   = 1'b1; // RULE17
              r_next.mem.addr = r_reg.channel_address_reg[r_reg.lvl];
            end else if (run && any_req) begin
              r_next.lvl      = win; // RULE21 RULE15
              r_next.ack      = 15'h0001 << win;
              r_next.mem.addr = r_reg.channel_address_reg[win];
              r_next.second   = 1'b0;
            end else begin
              r_next.mode    = csdcc_pkg::CSDCC_PROG; // RULE14
              r_next.ack     = 15'h0000;
              r_next.t_hold  = 1'b0;
              r_next.m_block = 1'b0;
            end
          end
          default: begin
          end
        endcase
      end
      default: begin
        r_next.mode = csdcc_pkg::CSDCC_PROG;
      end
    endcase
    // ahb data phase; a hardware set of a chk bit that is still clear wins over a clear
    if (r_reg.a_wr) begin
      case (r_reg.a_addr)
        `CSDCC_OFS_IO_CONTROL_COMMAND_WORD_ADDR: begin
          r_next.io_control_command_word_addr = HWDATA[15:0];
          r_next.bdata     = HWDATA[15:0];
        end
        `CSDCC_OFS_IO_CONTROL_COMMAND_WORD_CMD: begin
          if (HWDATA[`CSDCC_CMD_LVL_HI:0] < 4'(`CSDCC_NLEV)) begin
            r_next.channel_address_reg[HWDATA[3:0]]   = r_reg.io_control_command_word_addr; // RULE22
            r_next.func[HWDATA[3:0]]  = HWDATA[`CSDCC_CMD_FUNC_BIT];
            r_next.first[HWDATA[3:0]] = 1'b1;
            r_next.xio_chk = r_reg.io_control_command_word_addr != r_reg.bdata; // RULE22
          end
        end
        `CSDCC_OFS_CTRL:   r_next.ctrl  = HWDATA[1:0];
        `CSDCC_OFS_TMASK:  r_next.tmask = HWDATA[14:0];
        `CSDCC_OFS_STATUS: begin
          r_next.chk = (r_reg.chk & ~HWDATA[14:0]) | (r_next.chk & ~r_reg.chk);
          if (HWDATA[`CSDCC_ST_XCHK_BIT]) begin
            r_next.xio_chk = 1'b0;
          end
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      r_reg           <= '0;
      r_reg.mode      <= csdcc_pkg::CSDCC_PROG;
      r_reg.ctrl      <= `CSDCC_RST_CTRL;
      r_reg.io_control_command_word_addr <= `CSDCC_RST_WORD;
    end else begin
      r_reg <= r_next;
    end
  end

  assign HRDATA    = r_reg.hrdata;
  assign HREADYOUT = 1'b1;
  assign HRESP     = 1'b0;
  assign CS_ACK    = r_reg.ack;
  assign OUT_BUS   = r_reg.out_bus;
  assign OUT_STB   = r_reg.out_stb;
  assign CHK_STB   = r_reg.chk_stb;
  assign MEM_ADDR  = r_reg.mem.addr;
  assign MEM_RD    = r_reg.mem.rd;
  assign MEM_WR    = r_reg.mem.wr;
  assign MEM_WDATA = r_reg.mem.wdata;
  assign T_HOLD    = r_reg.t_hold;
  assign M_BLOCK   = r_reg.m_block;

  property p_ack_pri;
    @(posedge CLK) disable iff (SYS_RST)
    (r_reg.mode == csdcc_pkg::CSDCC_PROG && r_reg.ph == 3'h7 && run && any_req)
      |=> $onehot(CS_ACK) && CS_ACK == (15'h0001 << $past(win));
  endproperty
  a_ack_pri: assert property (p_ack_pri) else $error("ack not top level"); // RULE23

  property p_cab_addr;
    @(posedge CLK) disable iff (SYS_RST)
    (r_reg.mode == csdcc_pkg::CSDCC_STEAL && r_reg.ph > 3'h1)
      |-> MEM_ADDR == r_reg.cab;
  endproperty
  a_cab_addr: assert property (p_cab_addr) else $error("address not from cab"); // RULE5

  property p_start_t7;
    @(posedge CLK) disable iff (SYS_RST)
    $rose(T_HOLD) |-> $past(r_reg.ph) == 3'h7 && $past(run);
  endproperty
  a_start_t7: assert property (p_start_t7) else $error("steal not after T7"); // RULE16

  property p_hold_len;
    @(posedge CLK) disable iff (SYS_RST)
    $rose(T_HOLD) |-> (T_HOLD && M_BLOCK)[*8];
  endproperty
  a_hold_len: assert property (p_hold_len) else $error("steal shorter than a cycle"); // RULE17

  property p_car_inc;
    @(posedge CLK) disable iff (SYS_RST)
    (r_reg.mode == csdcc_pkg::CSDCC_STEAL && r_reg.ph == 3'h4 && !r_reg.setcar
     && !r_reg.a_wr)
      |=> r_reg.channel_address_reg[r_reg.lvl] == $past(r_reg.channel_address_reg[r_reg.lvl]) + 16'h0001;
  endproperty
  a_car_inc: assert property (p_car_inc) else $error("address did not advance"); // RULE6

  property p_car_set;
    @(posedge CLK) disable iff (SYS_RST)
    (r_reg.mode == csdcc_pkg::CSDCC_STEAL && r_reg.ph == 3'h3 && r_reg.setcar
     && !r_reg.a_wr)
      |=> ##1 r_reg.channel_address_reg[r_reg.lvl] == $past(MEM_RDATA, 2);
  endproperty
  a_car_set: assert property (p_car_set) else $error("next table address lost"); // RULE10

  property p_chk;
    @(posedge CLK) disable iff (SYS_RST)
    (r_reg.mode == csdcc_pkg::CSDCC_STEAL && r_reg.ph == 3'h5
     && CS_CTRL == 3'h6 && r_reg.bdata != r_reg.cab)
      |=> CHK_STB && r_reg.chk[r_reg.lvl];
  endproperty
  a_chk: assert property (p_chk) else $error("address check missed"); // RULE11

  property p_mem_steal;
    @(posedge CLK) disable iff (SYS_RST)
    (MEM_RD || MEM_WR || OUT_STB) |-> T_HOLD && $past(T_HOLD, 2);
  endproperty
  a_mem_steal: assert property (p_mem_steal) else $error("transfer outside steal"); // RULE7

  property p_lvl0_next;
    @(posedge CLK) disable iff (SYS_RST)
    (r_reg.mode == csdcc_pkg::CSDCC_STEAL && r_reg.ph == 3'h7 && CS_REQ[0]
     && run && !(r_reg.tmask[r_reg.lvl] && !r_reg.second))
      |=> T_HOLD && CS_ACK[0] ##7 T_HOLD;
  endproperty
  a_lvl0_next: assert property (p_lvl0_next) else $error("level zero left waiting"); // RULE15

  property p_first_out;
    @(posedge CLK) disable iff (SYS_RST)
    (r_reg.mode == csdcc_pkg::CSDCC_STEAL && r_reg.ph == 3'h4
     && r_reg.first[r_reg.lvl])
      |=> OUT_STB && OUT_BUS == $past(r_reg.bdata);
  endproperty
  a_first_out: assert property (p_first_out) else $error("count word not sent"); // RULE18

  property p_rd_data;
    @(posedge CLK) disable iff (SYS_RST)
    (r_reg.mode == csdcc_pkg::CSDCC_STEAL && r_reg.ph == 3'h3 && !r_reg.first[r_reg.lvl]
     && r_reg.func[r_reg.lvl] && !CS_CTRL[1] && !r_reg.a_wr)
      |=> r_reg.bdata == $past(IN_BUS);
  endproperty
  a_rd_data: assert property (p_rd_data) else $error("in-bus word not taken"); // RULE19

  property p_wr_data;
    @(posedge CLK) disable iff (SYS_RST)
    (r_reg.mode == csdcc_pkg::CSDCC_STEAL && r_reg.ph == 3'h4 && !r_reg.first[r_reg.lvl]
     && r_reg.func[r_reg.lvl] && !CS_CTRL[1])
      |=> MEM_WR && !OUT_STB && MEM_WDATA == $past(r_reg.bdata);
  endproperty
  a_wr_data: assert property (p_wr_data) else $error("in-bus word not stored"); // RULE19

  // a released level must hand the clock back in the very next cycle
  property p_release;
    @(posedge CLK) disable iff (SYS_RST)
    (r_reg.mode == csdcc_pkg::CSDCC_STEAL && r_reg.ph == 3'h7 && !(run && any_req)
     && !(r_reg.tmask[r_reg.lvl] && !r_reg.second))
      |=> !T_HOLD && !M_BLOCK && CS_ACK == 15'h0000;
  endproperty
  a_release: assert property (p_release) else $error("steal not released"); // RULE14
endmodule : csdcc_top

// [verif/csdcc_adapter.sv]
/*
 * partner model: a chaining adapter on level 0 plus a small core storage.
 * assumes every stolen cycle ends with an out-bus strobe or a storage write.
 */
`timescale 1ns/1ps
`include "csdcc_defines.svh"
module csdcc_adapter #(
  parameter logic [15:0] in_key = 16'h5A3C
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // start of a table run
  input  wire logic        start,
  // adapter lines
  input  wire logic [15:0] out_bus,
  input  wire logic        out_stb,
  output logic             req,
  output logic      [2:0]  ctrl,
  output logic      [15:0] in_bus,
  // core storage
  input  wire logic [15:0] mem_addr,
  input  wire logic        mem_rd,
  input  wire logic        mem_wr,
  input  wire logic [15:0] mem_wdata,
  output logic      [15:0] mem_rdata
);
  logic [15:0] mem [0:63];
  logic [13:0] wc;
  logic [1:0]  scan;
  logic [1:0]  step;
  logic        first;
  logic        irq;
  // plain always: the bench preloads storage words from outside
  always @(posedge clk) begin
    // in-bus word follows the address, so the bench can predict what lands
    in_bus <= mem_addr ^ in_key;
    mem_rdata <= mem_rd ? mem[mem_addr[5:0]] : ~mem_rdata;
    if (mem_wr) begin
      mem[mem_addr[5:0]] <= mem_wdata;
    end
    irq <= 1'b0;
    if (rst) begin
      req <= 1'b0;
      ctrl <= 3'h0;
      first <= 1'b0;
      step <= 2'h0;
    end else if (start) begin
      req <= 1'b1;
      first <= 1'b1;
      step <= 2'h0;
    end else if ((out_stb || mem_wr) && req) begin
      if (first || step == 2'h3) begin
        scan <= out_bus[`CSDCC_SCAN_HI:`CSDCC_SCAN_LO];
        wc <= out_bus[`CSDCC_WC_HI:`CSDCC_WC_LO];
        req <= out_bus[`CSDCC_WC_HI:`CSDCC_WC_LO] != 14'h0;
        first <= 1'b0;
        step <= 2'h0;
      end else if (step == 2'h1) begin
        step <= 2'h2;
        ctrl <= `CSDCC_CTL_CHECK;
      end else if (step == 2'h2) begin
        step <= 2'h3;
        ctrl <= 3'h0;
      end else begin
        wc <= wc - 14'h1;
        if (wc == 14'h1) begin
          irq <= ~scan[1];
          req <= scan[0];
          step <= {1'b0, scan[0]};
          ctrl <= scan[0] ? `CSDCC_CTL_SETCAR : 3'h0;
        end
      end
    end
  end
endmodule : csdcc_adapter

// [verif/cycle_steal_data_channel_chaining_tb.sv]
/*
 * testbench: two chained tables, a good and a bad self address, a zero
 * count ending the chain. assumes the adapter model and csdcc_top.
 */
`timescale 1ns/1ps
`include "csdcc_defines.svh"
module cycle_steal_data_channel_chaining_tb;
  logic        clk, sys_rst, hwrite, start, req, hreadyout, hresp;
  logic        out_stb, chk_stb, mem_rd, mem_wr, t_hold, m_block;
  logic [1:0]  htrans;
  logic [2:0]  cs_ctrl;
  logic [14:0] cs_ack;
  logic [15:0] in_bus, out_bus, mem_rdata, mem_addr, mem_wdata;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [15:0] exp_q[$];
  logic [31:0] wr_q[$];
  int          err_count, comparisons, chk_seen, irq_seen;
  localparam logic [15:0] in_key = 16'h5A3C;
  int          tbl[12] = '{16, 17, 18, 19, 20, 32, 33, 34, 35, 36, 48, 49};

  csdcc_top csdcc_top_inst (.CLK(clk), .SYS_RST(sys_rst), .HSEL(1'b1), .HADDR(haddr),
    .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hreadyout),
    .HRDATA(hrdata), .HREADYOUT(hreadyout), .HRESP(hresp), .CS_REQ({14'h0, req}),
    .CS_CTRL(cs_ctrl), .IN_BUS(in_bus), .CS_ACK(cs_ack), .OUT_BUS(out_bus),
    .OUT_STB(out_stb), .CHK_STB(chk_stb), .MEM_RDATA(mem_rdata), .MEM_ADDR(mem_addr),
    .MEM_RD(mem_rd), .MEM_WR(mem_wr), .MEM_WDATA(mem_wdata), .T_HOLD(t_hold),
    .M_BLOCK(m_block));
  csdcc_adapter #(.in_key(in_key)) csdcc_adapter_inst (.clk(clk), .rst(sys_rst),
    .start(start),
    .out_bus(out_bus), .out_stb(out_stb), .req(req), .ctrl(cs_ctrl), .in_bus(in_bus),
    .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_wdata(mem_wdata),
    .mem_rdata(mem_rdata));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic summarize;
    $display("comparisons=%0d err_count=%0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : summarize

  task automatic wait_ready;
    int k;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (hreadyout !== 1'b1 && k < 100);
    if (k >= 100) begin
      err_count++;
      summarize();
    end
  endtask : wait_ready

  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    wait_ready();
    htrans <= 2'h0;
    hwdata <= d;
    wait_ready();
    chk({31'h0, hresp}, 32'h0);
    r = hrdata;
  endtask : ahb

  task automatic run_table;
    int n;
    n = 0;
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    while ((exp_q.size() != 0 || wr_q.size() != 0) && n < 20000) begin
      @(posedge clk);
      n++;
    end
    if (n >= 20000) begin
      err_count++;
      summarize();
    end
    repeat (40) @(posedge clk);
  endtask : run_table

  // each strobed word is checked against the oldest expected word
  always @(posedge clk) begin
    if (chk_stb) chk_seen++;
    if (csdcc_adapter_inst.irq) irq_seen++;
    if (mem_wr) begin
      if (wr_q.size() == 0) chk({mem_addr, mem_wdata}, 32'hFFFF_FFFF);
      else chk({mem_addr, mem_wdata}, wr_q.pop_front());
    end
    if (out_stb) begin
      chk({15'h0, t_hold, m_block, cs_ack}, {15'h0, 2'h3, 15'h1});
      if (exp_q.size() == 0) chk({16'h0, out_bus}, 32'hFFFF_FFFF);
      else chk({16'h0, out_bus}, {16'h0, exp_q.pop_front()});
    end
  end

  initial begin
    void'($urandom(32'h5507));
    sys_rst = 1'b1;
    start = 1'b0;
    htrans = 2'h0;
    haddr = 32'h0;
    hwrite = 1'b0;
    hwdata = 32'h0;
    for (int i = 0; i < 64; i++) csdcc_adapter_inst.mem[i] = 16'($urandom);
    csdcc_adapter_inst.mem[16] = 16'h000D;
    csdcc_adapter_inst.mem[20] = 16'h0020;
    csdcc_adapter_inst.mem[32] = 16'h0020;
    csdcc_adapter_inst.mem[33] = 16'h0009;
    csdcc_adapter_inst.mem[36] = 16'h0030;
    csdcc_adapter_inst.mem[48] = 16'h0055;
    csdcc_adapter_inst.mem[49] = 16'h0000;
    csdcc_adapter_inst.mem[60] = 16'h0008;
    foreach (tbl[i]) exp_q.push_back(csdcc_adapter_inst.mem[tbl[i]]);
    repeat (12) @(posedge clk);
    sys_rst <= 1'b0;
    ahb(1'b1, `CSDCC_OFS_IO_CONTROL_COMMAND_WORD_ADDR, 32'h10, rd);
    ahb(1'b0, `CSDCC_OFS_IO_CONTROL_COMMAND_WORD_ADDR, 32'h0, rd);
    chk(rd, 32'h10);
    ahb(1'b0, 8'h40, 32'h0, rd);
    chk(rd, 32'h0);
    ahb(1'b1, `CSDCC_OFS_IO_CONTROL_COMMAND_WORD_CMD, 32'h0, rd);
    ahb(1'b1, `CSDCC_OFS_CTRL, 32'h1, rd);
    repeat (16) @(posedge clk);
    chk({17'h0, cs_ack}, 32'h0);
    $display("register setup done");
    run_table();
    chk(chk_seen, 1);
    chk(irq_seen, 2);
    chk({17'h0, cs_ack}, 32'h0);
    $display("chained scan done");
    ahb(1'b0, `CSDCC_OFS_STATUS, 32'h0, rd);
    chk(rd & 32'h0001_7FFF, 32'h1);
    ahb(1'b1, `CSDCC_OFS_STATUS, 32'h1, rd);
    ahb(1'b0, `CSDCC_OFS_STATUS, 32'h0, rd);
    chk(rd & 32'h0001_7FFF, 32'h0);
    $display("status check done");
    ahb(1'b1, `CSDCC_OFS_CTRL, 32'h2, rd);
    ahb(1'b0, `CSDCC_OFS_CTRL, 32'h0, rd);
    chk(rd, 32'h2);
    ahb(1'b1, `CSDCC_OFS_IO_CONTROL_COMMAND_WORD_ADDR, 32'h3C, rd);
    ahb(1'b1, `CSDCC_OFS_IO_CONTROL_COMMAND_WORD_CMD, 32'h10, rd);
    exp_q.push_back(16'h0008);
    wr_q.push_back({16'h003D, 16'h003D ^ in_key});
    wr_q.push_back({16'h003E, 16'h003E ^ in_key});
    run_table();
    chk(irq_seen, 3);
    chk({17'h0, cs_ack}, 32'h0);
    $display("read scan done");
    summarize();
  end
endmodule : cycle_steal_data_channel_chaining_tb
